// >>> rtl/ocw_regs.sv
// Ratio and step-weight command registers with the on-time adjust loop they steer.
// Assumes a command port already decoded from the serial host side, on core_clk,
// and loop events (period strobe, window result) from logic on the same clock.
// Weight values are trusted as written; the host keeps them inside their legal ranges.
`timescale 1ns/1ps
`include "ocw_defines.svh"
module ocw_regs #(
    parameter int TON_W = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Command register port
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_ack,
    // Loop events, one per PWM period
    input wire logic period_tick,
    input wire logic null_in_window,
    // Loop settings from other registers
    input wire logic [TON_W-1:0] ton_start,
    input wire logic [TON_W-1:0] ton_min,
    input wire logic [TON_W-1:0] ton_max,
    input wire logic [2:0] hyst_band,
    input wire logic latch_enable,
    // Loop results and decoded ratio code
    output logic [TON_W-1:0] ton_now,
    output logic [7:0] ton_frac,
    output logic ton_locked,
    output logic [3:0] ratio_code,
    output logic ratio_valid
);
    logic rst_meta, rst_sync;
    ocw_pkg::ocw_ratio_s ratio;
    ocw_pkg::ocw_weight_s weight;
    ocw_pkg::ocw_state_e state;
    logic [TON_W-1:0] ref_ton;
    logic [8:0] settle_cnt;
    logic seeded; // Set by the first period tick after reset
    // Position width: integer on-time units over an 8-bit fraction
    localparam int POS_W = TON_W + 8;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Address decode
    // Unmapped codes read as zero and writes to them fall away
    wire hit_ratio = (cmd_addr == `OCW_ADDR_RATIO);
    wire hit_weight = (cmd_addr == `OCW_ADDR_WEIGHT);
    wire [15:0] rd_mux = hit_ratio ? ratio : (hit_weight ? weight : 16'h0000);

    // Whole words are stored, reserved bits included, so they read back
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            ratio <= `OCW_RATIO_RESET;
            weight <= `OCW_WEIGHT_RESET;
        end else if (cmd_wr && hit_ratio) begin
            ratio <= cmd_wdata; // see (RULE_01) (RULE_02)
        end else if (cmd_wr && hit_weight) begin
            weight <= cmd_wdata; // see (RULE_02)
        end
    end

    // Read answer one cycle after the strobe
    // Data holds between reads so a slow host may still pick it up
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cmd_rdata <= 16'h0000;
            cmd_ack <= 1'b0;
        end else begin
            cmd_ack <= cmd_wr | cmd_rd;
            if (cmd_rd) begin
                cmd_rdata <= rd_mux;
            end
        end
    end

    // Ratio code: only the low field is used, zero means no ratio
    assign ratio_code = ratio.code; // see (RULE_01)
    assign ratio_valid = (ratio.code != 4'h0); // see (RULE_01)

    // Unsigned step in 1/256 units of 5 ns; host keeps weights legal
    // The first tick after reset starts from the start value, later ones from the last position
    wire [POS_W-1:0] pos_full = seeded ? {ton_now, ton_frac} : {ton_start, 8'h00};
    wire [POS_W-1:0] step_short = {{(POS_W-8){1'b0}}, weight.shorten}; // see (RULE_03) (RULE_05)
    wire [POS_W-1:0] step_long = {{(POS_W-7){1'b0}}, weight.lengthen}; // see (RULE_04) (RULE_06)
    wire [POS_W:0] sum_long = {1'b0, pos_full} + {1'b0, step_long};
    wire shrink_under = pos_full < step_short;
    // Both directions saturate rather than wrap, so a large weight cannot fold the on-time
    wire [POS_W-1:0] raw_short = shrink_under ? {POS_W{1'b0}} : pos_full - step_short;
    wire [POS_W-1:0] raw_long = sum_long[POS_W] ? {POS_W{1'b1}} : sum_long[POS_W-1:0];
    wire [POS_W-1:0] raw_next = null_in_window ? raw_short : raw_long; // see (RULE_07) (RULE_10)
    // Clamp the integer part, zeroing the fraction at either bound
    wire [TON_W-1:0] raw_int = raw_next[POS_W-1:8];
    wire below = raw_int < ton_min;
    wire above = raw_int > ton_max;
    wire [TON_W-1:0] next_ton = below ? ton_min : (above ? ton_max : raw_int); // see (RULE_09)
    wire [7:0] next_frac = (below || above) ? 8'h00 : raw_next[7:0]; // see (RULE_10)

    // Band check against the on-time seen when settling began
    wire [TON_W-1:0] diff = (next_ton > ref_ton) ? next_ton - ref_ton : ref_ton - next_ton;
    wire in_band = diff <= {{(TON_W-3){1'b0}}, hyst_band};
    wire settled = (settle_cnt == `OCW_SETTLE_PERIODS - 9'h001);

    // Adjust loop: one step per period until latched
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            ton_now <= '0;
            ton_frac <= 8'h00;
            ref_ton <= '0;
            seeded <= 1'b0;
            settle_cnt <= 9'h000;
            state <= ocw_pkg::OCW_TRACK;
        end else begin
            case (state)
                ocw_pkg::OCW_TRACK: begin
                    if (period_tick) begin
                        ton_now <= next_ton; // see (RULE_03) (RULE_04)
                        ton_frac <= next_frac;
                        seeded <= 1'b1;
                        if (!in_band) begin
                            ref_ton <= next_ton;
                            settle_cnt <= 9'h000;
                        end else if (settled && latch_enable) begin
                            state <= ocw_pkg::OCW_LATCHED; // see (RULE_08)
                        end else if (!settled) begin
                            settle_cnt <= settle_cnt + 9'h001;
                        end
                    end
                end
                ocw_pkg::OCW_LATCHED: begin
                    if (!latch_enable) begin
                        state <= ocw_pkg::OCW_TRACK;
                        settle_cnt <= 9'h000;
                        ref_ton <= ton_now;
                    end
                end
                default: begin
                    state <= ocw_pkg::OCW_TRACK;
                end
            endcase
        end
    end

    // Lock flag straight from the state register, so it cannot glitch
    assign ton_locked = (state == ocw_pkg::OCW_LATCHED);

    // Register port checks
    a_ack_follows: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_02)
        cmd_ack == $past(cmd_wr || cmd_rd))
        else $error("command ack not one cycle after strobe");
    a_ratio_store: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_01)
        cmd_wr && hit_ratio |=> ratio_code == $past(cmd_wdata[3:0]))
        else $error("ratio code not stored");
    a_ratio_whole: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_02)
        cmd_wr && hit_ratio |=> ratio == $past(cmd_wdata))
        else $error("ratio word not stored whole");
    a_weight_store: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_02)
        cmd_wr && hit_weight |=> weight == $past(cmd_wdata))
        else $error("weight word not stored whole");
    a_reserved_back: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_02)
        cmd_rd && !cmd_wr && hit_weight |=> cmd_rdata[7] == $past(weight.reserved))
        else $error("reserved bit lost");
    a_read_data: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_01)
        cmd_rd && !cmd_wr && hit_ratio |=> cmd_rdata[3:0] == ratio_code)
        else $error("ratio code read back wrong");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_02)
        cmd_rd && !cmd_wr && !hit_ratio && !hit_weight |=> cmd_rdata == 16'h0000)
        else $error("unmapped read not zero");

    // Adjust loop checks
    a_clamp_bounds: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_09)
        period_tick && state == ocw_pkg::OCW_TRACK && ton_min <= ton_max
        |=> ton_now >= $past(ton_min) && ton_now <= $past(ton_max))
        else $error("on-time left clamp range");
    a_short_step: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_03)
        period_tick && state == ocw_pkg::OCW_TRACK && null_in_window && !below && !above
        && !shrink_under |=> {ton_now, ton_frac} == $past(pos_full) - $past(step_short))
        else $error("shorten step wrong");
    a_long_step: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_04)
        period_tick && state == ocw_pkg::OCW_TRACK && !null_in_window && !below && !above
        && !sum_long[POS_W] |=> {ton_now, ton_frac} == $past(pos_full) + $past(step_long))
        else $error("lengthen step wrong");
    a_frac_slow: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_10)
        period_tick && state == ocw_pkg::OCW_TRACK && !null_in_window && !below && !above
        && seeded && ton_frac == 8'h00 && weight.lengthen != 7'h00 |=> ton_now == $past(ton_now))
        else $error("fraction carried too early");
    a_floor_frac: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_03)
        period_tick && state == ocw_pkg::OCW_TRACK && null_in_window && shrink_under
        |=> ton_frac == 8'h00)
        else $error("underflow left a fraction");

    // Settling and latch checks
    a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        ton_locked && latch_enable |=> ton_locked && $stable(ton_now))
        else $error("latched on-time moved");
    a_latch_frozen: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        ton_locked |=> $stable(ton_now) && $stable(ton_frac))
        else $error("tick moved a latched on-time");
    a_unlatch_drop: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        ton_locked && !latch_enable |=> !ton_locked)
        else $error("latch kept without enable");
    a_band_restart: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        period_tick && state == ocw_pkg::OCW_TRACK && !in_band |=> settle_cnt == 9'h000)
        else $error("settle count kept after leaving band");
    a_ticks_counted: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        period_tick && state == ocw_pkg::OCW_TRACK && in_band && !settled
        |=> settle_cnt == $past(settle_cnt) + 9'h001)
        else $error("in-band tick not counted");
    a_lock_enable: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        $rose(ton_locked) |-> $past(latch_enable))
        else $error("latched without enable");
    a_settle_need: assert property (@(posedge core_clk) disable iff (!rst_sync) // see (RULE_08)
        $rose(ton_locked) |-> $past(settle_cnt) == `OCW_SETTLE_PERIODS - 9'h001)
        else $error("latched before settling");
endmodule

// >>> rtl/ocw_defines.svh
// Constants for the on-time crossing weight register block.
// Assumes a 16-bit command register port and one 50 MHz core clock.
// How it works
// (RULE_01) The ratio register keeps a 4-bit winding-ratio code in bits 3:0, code k meaning 1/k and 0 meaning none.
// (RULE_02) Reserved bits 15:4 of the ratio register and bit 7 of the weight register store and read back but steer nothing.
// (RULE_03) A current null inside the valid window shortens the on-time by the weight in bits 15:8.
// (RULE_04) No current null inside the valid window lengthens the on-time by the weight in bits 6:0.
// (RULE_05) The host never writes the shortening weight as zero or 0xFF.
// (RULE_06) The host never writes the lengthening weight as zero or 0x01.
// (RULE_07) On-time moves in 5 ns units and weights are fractions of 256, one event per PWM period.
// (RULE_08) The on-time is latched after it stays inside the hysteresis band for 256 consecutive periods.
// (RULE_09) The adjusted on-time is clamped between the minimum and maximum on-time.
// (RULE_10) A fractional accumulator below the 5 ns unit makes small weights move the on-time slowly.
`ifndef OCW_DEFINES_SVH
`define OCW_DEFINES_SVH
`define OCW_ADDR_RATIO 8'h25
`define OCW_ADDR_WEIGHT 8'h29
`define OCW_RATIO_RESET 16'h0000
`define OCW_WEIGHT_RESET 16'h0810
`define OCW_SHORT_MSB 15
`define OCW_SHORT_LSB 8
`define OCW_LONG_MSB 6
`define OCW_LONG_LSB 0
`define OCW_CODE_MSB 3
`define OCW_FRAC_FULL 9'h100
`define OCW_UNIT_NS 5
`define OCW_SETTLE_PERIODS 9'h100
`endif

// >>> rtl/ocw_pkg.sv
// Types for the on-time crossing weight register block.
// Assumes the constants header is included by the design file.
package ocw_pkg;
    typedef struct packed {
        logic [7:0] shorten;
        logic reserved;
        logic [6:0] lengthen;
    } ocw_weight_s;
    typedef struct packed {
        logic [11:0] reserved;
        logic [3:0] code;
    } ocw_ratio_s;
    typedef enum logic [1:0] {
        OCW_TRACK = 2'b01,
        OCW_LATCHED = 2'b10
    } ocw_state_e;
endpackage

// >>> tb/ocw_host.sv
// Host-side model of the serial command master, already decoded to words.
// Assumes the register port contract: one-cycle strobes, ack a cycle later.
`timescale 1ns/1ps
module ocw_host (
    // Clock and answer
    input wire logic core_clk,
    input wire logic cmd_ack,
    input wire logic [15:0] cmd_rdata,
    // Requests
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_addr,
    output logic [15:0] cmd_wdata
);
    logic [15:0] last_d = 16'h0000;
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 16'hFFFF;
    end
    // Strobe is a pulse; data is scrambled when idle so stale words never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge core_clk);
        cmd_wr <= w;
        cmd_rd <= !w;
        cmd_addr <= a;
        cmd_wdata <= d;
        last_d = d;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        cmd_wdata <= ~last_d;
        q = 16'hXXXX;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            if (cmd_ack === 1'b1) begin
                q = cmd_rdata;
                break;
            end
        end
    endtask
    // Weight words handed in are kept inside the legal ranges
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        xfer(1'b0, a, 16'h0000, q);
    endtask
endmodule

// >>> tb/ocw_regs_bench.sv
// Self-checking bench for the ratio and step-weight registers and their loop.
// Assumes the host model drives the command port; ticks come from here.
`timescale 1ns/1ps
`include "ocw_defines.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module ocw_regs_bench;
    logic core_clk = 1'b0, rst_n = 1'b0, period_tick = 1'b0, null_in_window = 1'b0;
    logic cmd_wr, cmd_rd, cmd_ack, ton_locked, ratio_valid, latch_enable = 1'b0;
    logic [7:0] cmd_addr, ton_frac;
    logic [15:0] cmd_wdata, cmd_rdata, q;
    logic [9:0] ton_min = 10'h000, ton_max = 10'h3FF, ton_now, held;
    logic [2:0] hyst_band = 3'h2;
    logic [3:0] ratio_code;
    int err_count = 0, checks_done = 0;
    ocw_host host (.core_clk(core_clk), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
    ocw_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_ack(cmd_ack), .period_tick(period_tick), .null_in_window(null_in_window),
        .ton_start(10'h000), .ton_min(ton_min), .ton_max(ton_max), .hyst_band(hyst_band),
        .latch_enable(latch_enable), .ton_now(ton_now), .ton_frac(ton_frac),
        .ton_locked(ton_locked), .ratio_code(ratio_code), .ratio_valid(ratio_valid));
    // 50 MHz core clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Back-to-back ticks; results are read one edge after the last one lands
    task automatic run(input int n, input logic nl);
        @(posedge core_clk);
        period_tick <= 1'b1;
        null_in_window <= nl;
        repeat (n) @(posedge core_clk);
        period_tick <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic t_ratio();
        host.rd(`OCW_ADDR_RATIO, q);
        `CHK(q, `OCW_RATIO_RESET)
        host.wr(`OCW_ADDR_RATIO, 16'hFFF5);
        host.rd(`OCW_ADDR_RATIO, q);
        `CHK(q, 16'hFFF5)
        `CHK({ratio_valid, ratio_code}, 5'h15)
        host.wr(`OCW_ADDR_RATIO, 16'hFFF0);
        `CHK({ratio_valid, ratio_code}, 5'h00)
        host.rd(8'h26, q);
        `CHK(q, 16'h0000)
    endtask
    task automatic t_steps();
        host.rd(`OCW_ADDR_WEIGHT, q);
        `CHK(q, `OCW_WEIGHT_RESET)
        ton_min <= 10'h00A;
        ton_max <= 10'h014;
        host.wr(`OCW_ADDR_WEIGHT, 16'h40C0);
        host.rd(`OCW_ADDR_WEIGHT, q);
        `CHK(q, 16'h40C0)
        run(1, 1'b0);
        `CHK({ton_now, ton_frac}, 18'h00A00)
        run(4, 1'b0);
        `CHK({ton_now, ton_frac}, 18'h00B00)
        run(1, 1'b1);
        `CHK({ton_now, ton_frac}, 18'h00AC0)
        ton_max <= 10'h00B;
        host.wr(`OCW_ADDR_WEIGHT, 16'h407F);
        run(9, 1'b0);
        `CHK({ton_now, ton_frac}, 18'h00B00)
    endtask
    // Raised floor throws the first tick out of band, so settling counts from a known tick;
    // equal weights alternating then keep the on-time inside the band
    task automatic t_latch();
        ton_min <= 10'h010;
        ton_max <= 10'h014;
        latch_enable <= 1'b1;
        host.wr(`OCW_ADDR_WEIGHT, 16'h4040);
        run(1, 1'b0);
        `CHK({ton_now, ton_frac}, 18'h01000)
        for (int i = 0; i < 128; i++) begin
            run(1, 1'b0);
            if (i == 127) `CHK(ton_locked, 1'b0)
            run(1, 1'b1);
        end
        `CHK(ton_locked, 1'b1)
        held = ton_now;
        run(5, 1'b0);
        `CHK(ton_now, held)
        latch_enable <= 1'b0;
        @(posedge core_clk);
        @(posedge core_clk);
        `CHK(ton_locked, 1'b0)
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_ratio();
        t_steps();
        t_latch();
        results();
    end
    // Watchdog well beyond the roughly 850 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        results();
    end
endmodule
